// ### include/pmboc_pkg.sv
// Command codes, field layouts, reset values and types for the output control block
package pmboc_pkg;

  // Bus command codes
  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_ON_OFF = 8'h02;
  localparam logic [7:0] CMD_CLEAR = 8'h03;
  localparam logic [7:0] CMD_STORE_ALL = 8'h11;
  localparam logic [7:0] CMD_TRIM = 8'h22;
  localparam logic [7:0] CMD_MARGIN_HIGH = 8'h25;
  localparam logic [7:0] CMD_MARGIN_LOW = 8'h26;
  localparam logic [7:0] CMD_SCALE_LOOP = 8'h29;
  localparam logic [7:0] CMD_OC_WARN = 8'h4a;
  localparam logic [7:0] CMD_RISE = 8'h61;
  localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
  localparam logic [7:0] CMD_STATUS_TEMP = 8'h7d;
  localparam logic [7:0] CMD_STATUS_CML = 8'h7e;

  // Operation byte fields
  localparam int OP_ENABLE_BIT = 7;
  localparam int OP_MARGIN_MSB = 5;
  localparam int OP_MARGIN_LSB = 2;
  localparam logic [3:0] MG_LOW_IGNORE = 4'h5;
  localparam logic [3:0] MG_LOW_ACT = 4'h6;
  localparam logic [3:0] MG_HIGH_IGNORE = 4'h9;
  localparam logic [3:0] MG_HIGH_ACT = 4'ha;

  // On/off source configuration fields
  localparam int CFG_POWER_UP = 4;
  localparam int CFG_OBEY_CMD = 3;
  localparam int CFG_PIN_RESPOND = 2;
  localparam int CFG_PIN_POLARITY = 1;
  localparam logic [7:0] ONOFF_RESET = 8'h17;
  localparam logic [7:0] ONOFF_WMASK = 8'h1e;
  localparam logic [7:0] ONOFF_RO_ONE = 8'h01;

  // Fixed linear-format exponents
  localparam logic [4:0] EXP_RISE = 5'h1c;
  localparam logic [4:0] EXP_SCALE = 5'h17;
  localparam logic [4:0] EXP_OC = 5'h1f;

  localparam logic [10:0] SCALE_DEFAULT = 11'h100;
  localparam logic [10:0] SCALE_MAX = 11'h200;
  localparam logic [5:0] OC_WARN_DEFAULT = 6'h32;
  localparam logic [10:0] RISE_MANT [0:7] = '{11'h00a, 11'h00e, 11'h013, 11'h01d,
                                              11'h02b, 11'h043, 11'h060, 11'h090};

  // Reference in units of 2^-19 V: 600 mV nominal, 25 % of it as trim limit
  localparam logic signed [31:0] VREF_NOM_CODE = 32'sh0004_cccd;
  localparam logic signed [27:0] TRIM_LIMIT = 28'sh001_3333;

  // Status bit positions
  localparam int SB_CML = 1;
  localparam int SB_TEMP = 2;
  localparam int ST_OT_FAULT = 7;
  localparam int ST_OT_WARN = 6;

  // Synchroniser lanes
  localparam int SI_SCL = 0;
  localparam int SI_SDA = 1;
  localparam int SI_PIN = 2;
  localparam int SI_PWR = 3;
  localparam int SI_OTF = 4;
  localparam int SI_OTW = 5;
  localparam int NSYNC = 6;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_RX = 3'h1, ST_RACK = 3'h3, ST_TX = 3'h2, ST_TACK = 3'h6
  } pmboc_state_t;

  typedef enum logic [1:0] {MARGIN_OFF = 2'h0, MARGIN_LOW = 2'h1, MARGIN_HIGH = 2'h2} pmboc_margin_t;

  // Communication fault flags, msb first as they sit in the status byte
  typedef struct packed {
    logic bad_cmd;
    logic bad_data;
    logic pec_err;
  } pmboc_cml_t;

endpackage : pmboc_pkg

// ### rtl/pmboc_ctrl.sv
// Bus-controlled output enable, margin, trim and soft-start logic of the power module
`timescale 1ns/1ns
`default_nettype none

module pmboc_ctrl
  import pmboc_pkg::*;
#(
  parameter logic [7:0] OPERATION_DEFAULT = 8'h80,
  parameter logic [15:0] MARGIN_HIGH_DEFAULT = 16'h0000,
  parameter logic [15:0] MARGIN_LOW_DEFAULT = 16'h0000,
  parameter logic [2:0] RISE_DEFAULT = 3'h3
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic [6:0] addr_strap_in,
  input wire logic on_off_pin_in,
  input wire logic power_present_in,
  input wire logic ot_fault_in,
  input wire logic ot_warn_in,
  output var logic sda_out,
  output var logic sda_oe_n_out,
  output var logic alert_out,
  output var logic alert_oe_n_out,
  output var logic output_enable_out,
  output var logic [1:0] margin_sel_out,
  output var logic margin_act_fault_out,
  output var logic signed [31:0] vref_code_out,
  output var logic [2:0] rise_time_sel_out,
  output var logic [5:0] oc_warn_limit_out,
  output var logic store_pulse_out,
  output var logic [15:0] nv_margin_high_out,
  output var logic [15:0] nv_margin_low_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: a lane changes only once stages two and three agree

  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  logic [NSYNC-1:0] sync3;
  logic [NSYNC-1:0] filt;

  assign raw_in = {ot_warn_in, ot_fault_in, power_present_in, on_off_pin_in, sda_in, scl_in};

  for (genvar i = 0; i < NSYNC; i++) begin : g_sync
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        sync1[i] <= 1'b0;
        sync2[i] <= 1'b0;
        sync3[i] <= 1'b0;
        filt[i] <= 1'b0;
      end else begin
        sync1[i] <= raw_in[i];
        sync2[i] <= sync1[i];
        sync3[i] <= sync2[i];
        if (sync2[i] == sync3[i]) begin
          filt[i] <= sync3[i];
        end
      end
    end
  end

  logic prev_scl;
  logic prev_sda;
  logic [6:0] dev_addr;
  logic addr_taken;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prev_scl <= 1'b0;
      prev_sda <= 1'b0;
    end else begin
      prev_scl <= filt[SI_SCL];
      prev_sda <= filt[SI_SDA];
    end
  end

  // Address straps are caught once, on the first edge after reset release
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dev_addr <= 7'h00;
      addr_taken <= 1'b0;
    end else if (!addr_taken) begin
      dev_addr <= addr_strap_in;
      addr_taken <= 1'b1;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_rise = filt[SI_SCL] & ~prev_scl;
  assign scl_fall = ~filt[SI_SCL] & prev_scl;
  assign start_det = filt[SI_SCL] & prev_scl & prev_sda & ~filt[SI_SDA];
  assign stop_det = filt[SI_SCL] & prev_scl & ~prev_sda & filt[SI_SDA];

  function automatic logic [7:0] crc8_upd(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int k = 0; k < 8; k++) begin
      c = c[7] ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
    end
    return c;
  endfunction : crc8_upd

  ////////////////////////////////////////////////////////////////////////////
  // Register state and command decode

  logic [7:0] op;
  logic [7:0] onoff;
  logic [10:0] scale_m;
  logic [15:0] trim;
  logic [15:0] trim_applied;
  logic [15:0] margin_high;
  logic [15:0] margin_low;
  pmboc_cml_t cml;
  logic ot_fault_seen;
  logic ot_warn_seen;

  logic [7:0] cmd;
  logic [7:0] wbuf [0:2];
  logic [15:0] wword;
  logic [1:0] wr_len;
  logic wr_ok;
  logic [1:0] rd_len;
  logic [15:0] rd_word;

  assign wword = {wbuf[1], wbuf[0]};

  always_comb begin
    wr_ok = 1'b1;
    wr_len = 2'h2;
    rd_len = 2'h2;
    rd_word = 16'h0000;
    case (cmd)
      CMD_OPERATION: begin
        wr_len = 2'h1;
        rd_len = 2'h1;
        rd_word = {8'h00, op};
      end
      CMD_ON_OFF: begin
        wr_len = 2'h1;
        rd_len = 2'h1;
        rd_word = {8'h00, onoff};
      end
      CMD_CLEAR, CMD_STORE_ALL: begin
        wr_len = 2'h0;
        rd_len = 2'h0;
      end
      CMD_RISE: rd_word = {EXP_RISE, RISE_MANT[rise_time_sel_out]};
      CMD_SCALE_LOOP: rd_word = {EXP_SCALE, scale_m};
      CMD_TRIM: rd_word = trim;
      CMD_MARGIN_HIGH: rd_word = margin_high;
      CMD_MARGIN_LOW: rd_word = margin_low;
      CMD_OC_WARN: rd_word = {EXP_OC, 5'h00, oc_warn_limit_out};
      CMD_STATUS_BYTE: begin
        wr_ok = 1'b0;
        rd_len = 2'h1;
        rd_word[SB_CML] = |cml;
        rd_word[SB_TEMP] = ot_fault_seen | ot_warn_seen;
      end
      CMD_STATUS_TEMP: begin
        wr_ok = 1'b0;
        rd_len = 2'h1;
        rd_word[ST_OT_FAULT] = ot_fault_seen;
        rd_word[ST_OT_WARN] = ot_warn_seen;
      end
      CMD_STATUS_CML: begin
        wr_ok = 1'b0;
        rd_len = 2'h1;
        rd_word = {8'h00, cml, 5'h00};
      end
      default: begin
        wr_ok = 1'b0;
        rd_len = 2'h0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: bit engine, packet check and write commit at stop

  pmboc_state_t state;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic is_addr;
  logic rd_mode;
  logic in_txn;
  logic [2:0] wr_n;
  logic [1:0] tx_n;
  logic [7:0] crc;
  logic [7:0] tx_byte;
  logic [2:0] need_n;
  logic commit_p;
  logic ev_bad_cmd;
  logic ev_bad_len;
  logic ev_pec;

  assign need_n = {1'b0, wr_len} + 3'h2;

  always_comb begin
    if (tx_n < rd_len) begin
      tx_byte = (tx_n == 2'h0) ? rd_word[7:0] : rd_word[15:8];
    end else if (tx_n == rd_len) begin
      tx_byte = crc;
    end else begin
      tx_byte = 8'hff;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= ST_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      is_addr <= 1'b0;
      rd_mode <= 1'b0;
      in_txn <= 1'b0;
      wr_n <= 3'h0;
      tx_n <= 2'h0;
      crc <= 8'h00;
      cmd <= 8'h00;
      wbuf <= '{8'h00, 8'h00, 8'h00};
      sda_oe_n_out <= 1'b1;
      commit_p <= 1'b0;
      ev_bad_cmd <= 1'b0;
      ev_bad_len <= 1'b0;
      ev_pec <= 1'b0;
    end else begin
      commit_p <= 1'b0;
      ev_bad_cmd <= 1'b0;
      ev_bad_len <= 1'b0;
      ev_pec <= 1'b0;
      if (start_det) begin
        state <= ST_RX;
        bitcnt <= 4'h0;
        is_addr <= 1'b1;
        sda_oe_n_out <= 1'b1;
        if (!in_txn) begin
          crc <= 8'h00;
          wr_n <= 3'h0;
        end
      end else if (stop_det) begin
        state <= ST_IDLE;
        sda_oe_n_out <= 1'b1;
        in_txn <= 1'b0;
        if (in_txn && !rd_mode && wr_n != 3'h0) begin
          if (!wr_ok) begin
            ev_bad_cmd <= 1'b1;
          end else if (wr_n == need_n && crc == 8'h00) begin
            commit_p <= 1'b1;
          end else if (wr_n == need_n || wr_n == need_n - 3'h1) begin
            ev_pec <= 1'b1;
          end else begin
            ev_bad_len <= 1'b1;
          end
        end
      end else begin
        case (state)
          ST_RX: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], filt[SI_SDA]};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == 4'h8) begin
              is_addr <= 1'b0;
              if (is_addr && shreg[7:1] != dev_addr) begin
                state <= ST_IDLE;
              end else begin
                state <= ST_RACK;
                sda_oe_n_out <= 1'b0;
                crc <= crc8_upd(crc, shreg);
                if (is_addr) begin
                  rd_mode <= shreg[0];
                  in_txn <= 1'b1;
                  tx_n <= 2'h0;
                  if (shreg[0] && rd_len == 2'h0) begin
                    ev_bad_cmd <= 1'b1;
                  end
                end else begin
                  if (wr_n == 3'h0) begin
                    cmd <= shreg;
                  end else if (wr_n <= 3'h3) begin
                    wbuf[2'(wr_n - 3'h1)] <= shreg;
                  end
                  if (wr_n != 3'h7) begin
                    wr_n <= wr_n + 3'h1;
                  end
                end
              end
            end
          end
          ST_RACK, ST_TACK: begin
            if (state == ST_TACK && scl_rise && filt[SI_SDA]) begin
              state <= ST_IDLE;  // Master ended the read with a nack
            end else if (scl_fall) begin
              bitcnt <= 4'h0;
              if (rd_mode) begin
                state <= ST_TX;
                shreg <= tx_byte;
                sda_oe_n_out <= tx_byte[7];
                if (tx_n < rd_len) begin
                  crc <= crc8_upd(crc, tx_byte);
                end
                if (tx_n != 2'h3) begin
                  tx_n <= tx_n + 2'h1;
                end
              end else begin
                state <= ST_RX;
                sda_oe_n_out <= 1'b1;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bitcnt == 4'h7) begin
                state <= ST_TACK;
                sda_oe_n_out <= 1'b1;
              end else begin
                shreg <= {shreg[6:0], 1'b0};
                sda_oe_n_out <= shreg[6];
                bitcnt <= bitcnt + 4'h1;
              end
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write checks and configuration registers

  logic [7:0] rise_hit;
  logic [2:0] rise_idx;
  logic signed [27:0] trim_prod;
  logic trim_ok;
  logic [3:0] wr_margin;
  logic op_ok;
  logic data_ok;
  logic ev_bad_data;

  for (genvar k = 0; k < 8; k++) begin : g_rise
    assign rise_hit[k] = (wword[10:0] == RISE_MANT[k]);
  end

  always_comb begin
    rise_idx = 3'h0;
    for (int k = 0; k < 8; k++) begin
      if (rise_hit[k]) begin
        rise_idx = 3'(k);
      end
    end
  end

  assign trim_prod = $signed(wword) * $signed({1'b0, scale_m});
  assign trim_ok = (wword[15] == wword[14]) && (trim_prod <= TRIM_LIMIT)
                   && (trim_prod >= -TRIM_LIMIT);
  assign wr_margin = wbuf[0][OP_MARGIN_MSB:OP_MARGIN_LSB];
  assign op_ok = (wr_margin[3:2] == 2'h0) || (wr_margin == MG_LOW_IGNORE)
                 || (wr_margin == MG_LOW_ACT) || (wr_margin == MG_HIGH_IGNORE)
                 || (wr_margin == MG_HIGH_ACT);

  always_comb begin
    case (cmd)
      CMD_OPERATION: data_ok = op_ok;
      CMD_RISE: data_ok = (wword[15:11] == EXP_RISE) && (|rise_hit);
      CMD_SCALE_LOOP: data_ok = (wword[15:11] == EXP_SCALE) && (wword[10:0] != 11'h000)
                                && (wword[10:0] <= SCALE_MAX);
      CMD_MARGIN_HIGH, CMD_MARGIN_LOW: data_ok = ~wword[15];
      CMD_OC_WARN: data_ok = (wword[15:11] == EXP_OC) && (wword[10:6] == 5'h00);
      CMD_TRIM: data_ok = trim_ok;
      default: data_ok = 1'b1;
    endcase
  end

  assign ev_bad_data = commit_p & ~data_ok;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      op <= OPERATION_DEFAULT;
      onoff <= ONOFF_RESET;
      scale_m <= SCALE_DEFAULT;
      trim <= 16'h0000;
      trim_applied <= 16'h0000;
      margin_high <= MARGIN_HIGH_DEFAULT;
      margin_low <= MARGIN_LOW_DEFAULT;
      rise_time_sel_out <= RISE_DEFAULT;
      oc_warn_limit_out <= OC_WARN_DEFAULT;
    end else if (commit_p) begin
      case (cmd)
        CMD_OPERATION: if (data_ok) op <= wbuf[0];
        CMD_ON_OFF: onoff <= (wbuf[0] & ONOFF_WMASK) | ONOFF_RO_ONE;
        CMD_RISE: if (data_ok) rise_time_sel_out <= rise_idx;
        CMD_SCALE_LOOP: if (data_ok) scale_m <= wword[10:0];
        CMD_MARGIN_HIGH: if (data_ok) margin_high <= wword;
        CMD_MARGIN_LOW: if (data_ok) margin_low <= wword;
        CMD_OC_WARN: if (data_ok) oc_warn_limit_out <= wword[5:0];
        CMD_TRIM: begin
          trim <= wword;
          trim_applied <= trim_ok ? wword : 16'h0000;
        end
        default: ;
      endcase
    end
  end

  // Margins are copied only on the store command; reload from storage lies outside
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      nv_margin_high_out <= MARGIN_HIGH_DEFAULT;
      nv_margin_low_out <= MARGIN_LOW_DEFAULT;
      store_pulse_out <= 1'b0;
    end else begin
      store_pulse_out <= commit_p && cmd == CMD_STORE_ALL;
      if (commit_p && cmd == CMD_STORE_ALL) begin
        nv_margin_high_out <= margin_high;
        nv_margin_low_out <= margin_low;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status flags and alert; an event in the clearing cycle survives

  logic clear_p;

  assign clear_p = commit_p && cmd == CMD_CLEAR;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cml <= '0;
      ot_fault_seen <= 1'b0;
      ot_warn_seen <= 1'b0;
      alert_out <= 1'b0;
      alert_oe_n_out <= 1'b1;
      sda_out <= 1'b0;
    end else begin
      cml.bad_cmd <= ev_bad_cmd | (cml.bad_cmd & ~clear_p);
      cml.bad_data <= ev_bad_data | ev_bad_len | (cml.bad_data & ~clear_p);
      cml.pec_err <= ev_pec | (cml.pec_err & ~clear_p);
      ot_fault_seen <= filt[SI_OTF] | (ot_fault_seen & ~clear_p);
      ot_warn_seen <= filt[SI_OTW] | (ot_warn_seen & ~clear_p);
      alert_oe_n_out <= ~(|cml | ot_fault_seen | ot_warn_seen);
      alert_out <= 1'b0;
      sda_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output enable, margin selection and reference setpoint

  logic pin_active;
  logic next_enable;
  pmboc_margin_t next_margin;
  logic [3:0] op_margin;
  logic signed [16:0] mg_sum;
  logic signed [28:0] mg_prod;
  logic signed [27:0] trim_term;
  logic signed [31:0] next_vref;

  assign pin_active = ~(filt[SI_PIN] ^ onoff[CFG_PIN_POLARITY]);
  assign op_margin = op[OP_MARGIN_MSB:OP_MARGIN_LSB];

  always_comb begin
    next_enable = filt[SI_PWR];
    if (onoff[CFG_POWER_UP]) begin
      if (onoff[CFG_OBEY_CMD] && !op[OP_ENABLE_BIT]) begin
        next_enable = 1'b0;
      end
      if (onoff[CFG_PIN_RESPOND] && !pin_active) begin
        next_enable = 1'b0;
      end
    end
  end

  always_comb begin
    case (op_margin)
      MG_LOW_IGNORE, MG_LOW_ACT: next_margin = MARGIN_LOW;
      MG_HIGH_IGNORE, MG_HIGH_ACT: next_margin = MARGIN_HIGH;
      default: next_margin = MARGIN_OFF;
    endcase
  end

  // Reference in 2^-19 V: (volts at 2^-10) times divider mantissa at 2^-9
  assign mg_sum = (next_margin == MARGIN_HIGH) ? $signed({margin_high[15], margin_high})
                  + $signed({trim_applied[15], trim_applied})
                  : $signed({margin_low[15], margin_low})
                  + $signed({trim_applied[15], trim_applied});
  assign mg_prod = mg_sum * $signed({1'b0, scale_m});
  assign trim_term = $signed(trim_applied) * $signed({1'b0, scale_m});

  always_comb begin
    if (next_margin == MARGIN_OFF) begin
      next_vref = VREF_NOM_CODE + 32'(trim_term);
    end else begin
      next_vref = 32'(mg_prod);
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      output_enable_out <= 1'b0;
      margin_sel_out <= MARGIN_OFF;
      margin_act_fault_out <= 1'b0;
      vref_code_out <= VREF_NOM_CODE;
    end else begin
      output_enable_out <= next_enable;
      margin_sel_out <= next_margin;
      margin_act_fault_out <= (next_margin != MARGIN_OFF) && op[3];
      vref_code_out <= next_vref;
    end
  end

endmodule : pmboc_ctrl

`default_nettype wire

// ### test/pmboc_ctrl_assertions.sv
// Port assertions for the output control block
`timescale 1ns/1ns
`default_nettype none
module pmboc_chk
  import pmboc_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic power_present_in,
  input wire logic ot_fault_in,
  input wire logic sda_out,
  input wire logic alert_out,
  input wire logic alert_oe_n_out,
  input wire logic output_enable_out,
  input wire logic [1:0] margin_sel_out,
  input wire logic margin_act_fault_out,
  input wire logic store_pulse_out,
  input wire logic [15:0] nv_margin_high_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  AST_PWR_LOSS: assert property (
    $fell(power_present_in) |-> ##[1:10] !output_enable_out) else $error("on after power loss");
  AST_NO_PWR: assert property (
    !power_present_in [*8] |-> !output_enable_out) else $error("on without power");
  AST_ACT_MARGIN: assert property (
    margin_act_fault_out |-> margin_sel_out != MARGIN_OFF) else $error("act without margin");
  AST_MARGIN_CODE: assert property (
    margin_sel_out != 2'h3) else $error("bad margin select");
  AST_STORE_PULSE: assert property (
    store_pulse_out |=> !store_pulse_out) else $error("store pulse too long");
  AST_NV_SAVE: assert property (
    $changed(nv_margin_high_out) |-> store_pulse_out || $past(store_pulse_out))
    else $error("saved margin changed alone");
  AST_OT_ALERT: assert property (
    $rose(ot_fault_in) |-> ##[1:10] !alert_oe_n_out) else $error("no overtemp alert");
  AST_OD_LOW: assert property (
    !sda_out && !alert_out) else $error("open drain value not low");
endmodule : pmboc_chk
bind pmboc_ctrl pmboc_chk pmboc_chk_inst (.*);
`default_nettype wire

// ### test/pmboc_host.sv
// Bus host model issuing bit-banged writes with a check byte
`timescale 1ns/1ns
`default_nettype none
module pmboc_host (
  output logic scl_out,
  output logic sda_out,
  input wire logic sda_in
);
  logic [7:0] crc = 8'h00;
  int nacks = 0;
  initial scl_out = 1'b1;
  initial sda_out = 1'b1;
  task automatic bit_io(input logic b, output logic s);
    // Long low phase: the slave releases data several clocks after each falling edge
    sda_out = b;
    #150 scl_out = 1'b1;
    #100 s = sda_in;
    #50 scl_out = 1'b0;
    #100;
  endtask : bit_io
  task automatic byte_out(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
      crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ d[i]) ? 8'h07 : 8'h00);
    end
    // Released for the acknowledge, so only the pull-up holds it high
    bit_io(1'b1, s);
    if (s !== 1'b0) nacks++;
  endtask : byte_out
  task automatic write(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d,
                       input int n, input logic bad);
    crc = 8'h00;
    sda_out = 1'b0;
    #200 scl_out = 1'b0;
    #100 byte_out({a, 1'b0});
    byte_out(c);
    for (int i = 0; i < n; i++) byte_out(d[8*i +: 8]);
    byte_out(crc ^ {7'h00, bad});
    sda_out = 1'b0;
    #100 scl_out = 1'b1;
    #100 sda_out = 1'b1;
    #400;
  endtask : write
  task automatic read(input logic [6:0] a, input logic [7:0] c, input int n,
                      output logic [15:0] d, output logic ok);
    logic s;
    crc = 8'h00;
    d = 16'h0000;
    sda_out = 1'b0;
    #200 scl_out = 1'b0;
    #100 byte_out({a, 1'b0});
    byte_out(c);
    // Repeated start: data falls while the clock is high
    sda_out = 1'b1;
    #150 scl_out = 1'b1;
    #100 sda_out = 1'b0;
    #100 scl_out = 1'b0;
    #50 byte_out({a, 1'b1});
    for (int i = 0; i <= n; i++) begin
      for (int j = 7; j >= 0; j--) begin
        bit_io(1'b1, s);
        crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ s) ? 8'h07 : 8'h00);
        if (i < n) d[8*i + j] = s;
      end
      // Acknowledge data bytes, refuse after the check byte
      bit_io(i == n, s);
    end
    ok = (crc == 8'h00);
    sda_out = 1'b0;
    #100 scl_out = 1'b1;
    #100 sda_out = 1'b1;
    #400;
  endtask : read
endmodule : pmboc_host
`default_nettype wire

// ### test/test_pmboc_ctrl.sv
// Self-checking bench for the output control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("ERROR %0t %h %h", $time, (a), (e)); end end
module test_pmboc_ctrl;
  import pmboc_pkg::*;
  localparam logic [6:0] ADDR = 7'h2a;
  logic clk, rst_n, pin, pwr, otf, otw, scl, hsda, oen, aoen, en, act;
  logic [1:0] msel;
  logic [2:0] rise;
  logic [5:0] oc;
  logic [15:0] nvh, nvl;
  logic signed [31:0] vref;
  int error_cnt = 0;
  int n_checks = 0;
  wire logic sda;
  assign sda = hsda & oen;
  pmboc_ctrl pmboc_ctrl_inst (.ref_clk_in(clk), .rst_n_in(rst_n), .scl_in(scl), .sda_in(sda),
    .addr_strap_in(ADDR), .on_off_pin_in(pin), .power_present_in(pwr), .ot_fault_in(otf),
    .ot_warn_in(otw), .sda_out(), .sda_oe_n_out(oen), .alert_out(), .alert_oe_n_out(aoen),
    .output_enable_out(en), .margin_sel_out(msel), .margin_act_fault_out(act),
    .vref_code_out(vref), .rise_time_sel_out(rise), .oc_warn_limit_out(oc),
    .store_pulse_out(), .nv_margin_high_out(nvh), .nv_margin_low_out(nvl));
  pmboc_host pmboc_host_inst (.scl_out(scl), .sda_out(hsda), .sda_in(sda));
  //////////////////////////////
  task automatic report_and_stop();
    if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input int n, input logic b = 0);
    pmboc_host_inst.write(ADDR, c, d, n, b);
    repeat (12) @(negedge clk);
  endtask : wr
  task automatic want_en(input logic v);
    for (int i = 0; i < 30 && en !== v; i++) @(negedge clk);
    `CHK(en, v)
    if (en !== v) report_and_stop();
  endtask : want_en
  task automatic rd_chk(input logic [7:0] c, input logic [7:0] e);
    logic [15:0] d;
    logic ok;
    pmboc_host_inst.read(ADDR, c, 1, d, ok);
    repeat (12) @(negedge clk);
    `CHK({ok, d}, {1'b1, 8'h00, e})
  endtask : rd_chk
  //////////////////////////////
  task automatic t_pin();
    `CHK({vref, rise, oc}, {VREF_NOM_CODE, 3'h3, OC_WARN_DEFAULT})
    want_en(1'b0);
    pin = 1'b1;
    want_en(1'b1);
    pin = 1'b0;
    want_en(1'b0);
  endtask : t_pin
  task automatic t_cfg();
    wr(CMD_ON_OFF, 16'h0000, 1);
    want_en(1'b1);
    wr(CMD_ON_OFF, 16'h0018, 1);
    rd_chk(CMD_ON_OFF, 8'h19);
    wr(CMD_OPERATION, 16'h0000, 1);
    want_en(1'b0);
    wr(CMD_OPERATION, 16'h0080, 1);
    want_en(1'b1);
    pwr = 1'b0;
    want_en(1'b0);
    pwr = 1'b1;
  endtask : t_cfg
  task automatic t_margin();
    logic [7:0] op [6] = '{8'h94, 8'h98, 8'ha4, 8'ha8, 8'h9c, 8'h80};
    logic [2:0] ex [6] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h5, 3'h0};
    for (int i = 0; i < 6; i++) begin
      wr(CMD_OPERATION, {8'h00, op[i]}, 1);
      `CHK({msel, act}, ex[i])
    end
  endtask : t_margin
  task automatic t_trim();
    wr(CMD_TRIM, 16'h0133, 2, 1'b1);
    `CHK(vref, VREF_NOM_CODE)
    wr(CMD_TRIM, 16'h0133, 2);
    `CHK(vref, VREF_NOM_CODE + 32'sh13300)
    wr(CMD_MARGIN_HIGH, 16'h0400, 2);
    wr(CMD_OPERATION, 16'h00a4, 1);
    `CHK(vref, 32'sh53300)
    wr(CMD_MARGIN_LOW, 16'h0300, 2);
    wr(CMD_STORE_ALL, 16'h0000, 0);
    `CHK({nvh, nvl}, {16'h0400, 16'h0300})
    wr(CMD_OPERATION, 16'h0080, 1);
    wr(CMD_CLEAR, 16'h0000, 0);
    wr(CMD_TRIM, 16'h0134, 2);
    `CHK({aoen, vref}, {1'b0, VREF_NOM_CODE})
    rd_chk(CMD_STATUS_BYTE, 8'h02);
    rd_chk(CMD_STATUS_CML, 8'h40);
  endtask : t_trim
  task automatic t_word();
    for (int i = 7; i >= 0; i--) begin
      wr(CMD_RISE, {EXP_RISE, RISE_MANT[i]}, 2);
      `CHK(rise, 3'(i))
    end
    wr(CMD_RISE, {EXP_RISE, 11'h00b}, 2);
    wr(CMD_OC_WARN, {EXP_OC, 11'h03f}, 2);
    wr(CMD_OC_WARN, {EXP_OC, 11'h07f}, 2);
    `CHK({rise, oc}, {3'h0, 6'h3f})
    wr(CMD_SCALE_LOOP, {EXP_SCALE, 11'h200}, 2);
    wr(CMD_SCALE_LOOP, {EXP_SCALE, 11'h201}, 2);
    wr(CMD_TRIM, 16'h0099, 2);
    `CHK(vref, VREF_NOM_CODE + 32'sh13200)
  endtask : t_word
  task automatic t_alert();
    wr(CMD_CLEAR, 16'h0000, 0);
    `CHK(aoen, 1'b1)
    otf = 1'b1;
    otw = 1'b1;
    repeat (10) @(negedge clk);
    otf = 1'b0;
    otw = 1'b0;
    `CHK(aoen, 1'b0)
    rd_chk(CMD_STATUS_TEMP, 8'hc0);
    wr(CMD_CLEAR, 16'h0000, 0);
    `CHK(aoen, 1'b1)
  endtask : t_alert
  //////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    pin = 1'b0;
    pwr = 1'b1;
    otf = 1'b0;
    otw = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (12) @(negedge clk);
    t_pin();
    t_cfg();
    t_margin();
    t_trim();
    t_word();
    t_alert();
    `CHK(pmboc_host_inst.nacks, 0)
    report_and_stop();
  end
endmodule : test_pmboc_ctrl
`default_nettype wire
